// >>> hdl/sds_defs.vh
// constants for the smart data sector builder
`ifndef SDS_DEFS_VH
`define SDS_DEFS_VH

// register word indices (byte offset = index * 4)
`define SDS_REG_CMD       4'h0
`define SDS_REG_STATUS    4'h1
`define SDS_REG_DATA      4'h2
`define SDS_REG_CFG       4'h3
`define SDS_REG_THRESH    4'h4
`define SDS_REG_SPARE_SEL 4'h5
`define SDS_REG_SPARE_SUM 4'h6
`define SDS_REG_LIFE      4'h7
`define SDS_REG_ERASE_LO  4'h8
`define SDS_REG_ERASE_HI  4'h9
`define SDS_REG_ECC       4'ha
`define SDS_REG_COMMIT    4'hb
`define SDS_REG_WEAR_THR  4'hc

// reset values
`define SDS_RST_CFG       32'h0002_0000
`define SDS_RST_LIFE      32'h0000_0064
`define SDS_PCT_FULL      8'h64

// task file command decode
`define SDS_SIG_CYL_HI    8'hc2
`define SDS_SIG_CYL_LO    8'h4f
`define SDS_FEAT_READ     8'hd0
`define SDS_FEAT_THRESH   8'hd1
`define SDS_FEAT_AUTOSAVE 8'hd2
`define SDS_FEAT_ENABLE   8'hd8
`define SDS_FEAT_DISABLE  8'hd9
`define SDS_FEAT_STATUS   8'hda

// sector layout
`define SDS_VER_OLD       16'h0004
`define SDS_VER_NEW       16'h0010
`define SDS_ENT_SPARE     9'h002
`define SDS_ENT_ERASE     9'h00e
`define SDS_ENT_ECC       9'h01a
`define SDS_ENT_END       9'h026
`define SDS_TAIL_BASE     9'h16a
`define SDS_TAIL_END      9'h18e
`define SDS_LAST_SUM      10'h1fe
`define SDS_CHK_OFS       9'h1ff
`define SDS_SECTOR_END    10'h200
`define SDS_SMART_CAPS    16'h0003

// attribute identifiers and flags
`define SDS_ID_SPARE      8'hc4
`define SDS_ID_ERASE      8'he5
`define SDS_ID_ECC        8'hcb
`define SDS_FLG_PREFAIL   16'h0003
`define SDS_FLG_ADVISORY  16'h0002

`endif

// >>> hdl/sds_pct_div.v
// sequential divider giving 100 * current / initial, saturated to 100
`timescale 1ns/10ps
`default_nettype none
`include "sds_defs.vh"
module sds_pct_div #(
    parameter W = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // request
    input wire start,
    input wire [W-1:0] cur,
    input wire [W-1:0] init,
    // result
    output reg [7:0] pct_reg,
    output reg busy_reg
);
    localparam NUMW = W + 7;

    reg [NUMW-1:0] num_reg;
    reg [NUMW-1:0] q_reg;
    reg [W:0] rem_reg;
    reg [W-1:0] den_reg;
    reg [5:0] cnt_reg;

    wire [W-1:0] cur_c = (cur > init) ? init : cur;
    wire [NUMW-1:0] prod = {7'b0, cur_c} * {{(NUMW-8){1'b0}}, `SDS_PCT_FULL};
    wire [W:0] trial = {rem_reg[W-1:0], num_reg[NUMW-1]};
    wire fit = (trial >= {1'b0, den_reg});
    wire [NUMW-1:0] q_next = {q_reg[NUMW-2:0], fit};

    // ----------------------------------------
    // restoring division, one quotient bit per clock
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            num_reg <= {NUMW{1'b0}};
            q_reg <= {NUMW{1'b0}};
            rem_reg <= {(W+1){1'b0}};
            den_reg <= {W{1'b0}};
            cnt_reg <= 6'h00;
            pct_reg <= `SDS_PCT_FULL;
            busy_reg <= 1'b0;
        end else if (start) begin
            num_reg <= prod;
            den_reg <= init;
            q_reg <= {NUMW{1'b0}};
            rem_reg <= {(W+1){1'b0}};
            cnt_reg <= NUMW[5:0];
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            num_reg <= {num_reg[NUMW-2:0], 1'b0};
            q_reg <= q_next;
            rem_reg <= fit ? (trial - {1'b0, den_reg}) : trial;
            cnt_reg <= cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
                busy_reg <= 1'b0;
                // no spares defined counts as untouched
                pct_reg <= (den_reg == {W{1'b0}}) ? `SDS_PCT_FULL : q_next[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/sds_builder.v
// smart read-data sector builder with avalon-mm register slave
`timescale 1ns/10ps
`default_nettype none
`include "sds_defs.vh"
module sds_builder #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_SUM = 3'd1;
    localparam ST_LO = 3'd2;
    localparam ST_HI = 3'd3;
    localparam ST_HOLD = 3'd4;
    localparam ST_WAIT = 3'd5;

    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    reg [2:0] state_reg;
    reg [9:0] idx_reg;
    reg [7:0] sum_reg;
    reg [7:0] chk_reg;
    reg [15:0] word_reg;
    reg abort_reg;
    reg done_reg;
    reg thr_reg;
    reg [7:0] spare_worst_reg;
    reg [7:0] erase_worst_reg;
    reg div_start_reg;
    reg [31:0] regs_reg [0:12];
    reg [31:0] rd_next;
    reg [7:0] gen_byte;
    reg [8:0] off;
    integer i;

    // ----------------------------------------
    // register fields
    // ----------------------------------------
    wire layout_new = regs_reg[`SDS_REG_CFG][0];
    wire global_wl = regs_reg[`SDS_REG_CFG][1];
    wire global_bbm = regs_reg[`SDS_REG_CFG][2];
    wire [15:0] content_ver = regs_reg[`SDS_REG_CFG][31:16];
    wire [7:0] spare_thr = regs_reg[`SDS_REG_THRESH][7:0];
    wire [7:0] erase_thr = regs_reg[`SDS_REG_THRESH][15:8];
    wire [15:0] sel_init = regs_reg[`SDS_REG_SPARE_SEL][15:0];
    wire [15:0] sel_cur = regs_reg[`SDS_REG_SPARE_SEL][31:16];
    wire [15:0] sum_init = regs_reg[`SDS_REG_SPARE_SUM][15:0];
    wire [15:0] sum_cur = regs_reg[`SDS_REG_SPARE_SUM][31:16];
    wire [7:0] life = regs_reg[`SDS_REG_LIFE][7:0];
    wire [63:0] erase_total = {regs_reg[`SDS_REG_ERASE_HI], regs_reg[`SDS_REG_ERASE_LO]};
    wire [31:0] ecc_count = regs_reg[`SDS_REG_ECC];
    wire [31:0] commit_cnt = regs_reg[`SDS_REG_COMMIT];
    wire [31:0] wear_thr = regs_reg[`SDS_REG_WEAR_THR];

    // ----------------------------------------
    // spare percentage
    // ----------------------------------------
    wire [7:0] spare_val;
    wire div_busy;

    sds_pct_div #(
        .W(CNT_W)
    ) u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(div_start_reg),
        .cur(sel_cur[CNT_W-1:0]),
        .init(sel_init[CNT_W-1:0]),
        .pct_reg(spare_val),
        .busy_reg(div_busy)
    );

    // ----------------------------------------
    // avalon decode
    // ----------------------------------------
    wire [3:0] ridx = avs_address[5:2];
    wire mapped = (avs_address[7:6] == 2'b00) && (ridx <= `SDS_REG_WEAR_THR);
    wire writable = mapped && (ridx != `SDS_REG_STATUS) && (ridx != `SDS_REG_DATA);
    wire req = (avs_read || avs_write) && avs_waitrequest;
    wire busy = (state_reg != ST_IDLE);
    wire data_rd = avs_read && mapped && (ridx == `SDS_REG_DATA);
    wire stall = data_rd && busy && (state_reg != ST_HOLD);
    wire take = req && !stall;
    wire pop = take && data_rd && (state_reg == ST_HOLD);
    wire cmd_go = take && avs_write && mapped && (ridx == `SDS_REG_CMD) && !busy;
    wire [7:0] feat = avs_writedata[7:0];
    wire sig_ok = (avs_writedata[15:8] == `SDS_SIG_CYL_LO) &&
                  (avs_writedata[23:16] == `SDS_SIG_CYL_HI);

    // ----------------------------------------
    // sector contents
    // ----------------------------------------
    wire [15:0] ver_word = layout_new ? `SDS_VER_NEW : `SDS_VER_OLD;
    // entries are packed byte 0 in the low bits, so slicing is little endian
    wire [95:0] ent_spare = layout_new ?
        {8'h00, sum_cur, sel_cur, sel_init, spare_worst_reg, spare_val,
         `SDS_FLG_PREFAIL, `SDS_ID_SPARE} :
        {sum_cur, sum_init, sel_cur, sel_init, spare_val,
         `SDS_FLG_PREFAIL, `SDS_ID_SPARE};
    wire [95:0] ent_erase = layout_new ?
        {8'h00, erase_total[47:0], erase_worst_reg, life,
         `SDS_FLG_ADVISORY, `SDS_ID_ERASE} :
        {erase_total, life, `SDS_FLG_ADVISORY, `SDS_ID_ERASE};
    wire [95:0] ent_ecc = layout_new ?
        {24'h0, ecc_count, `SDS_PCT_FULL, `SDS_PCT_FULL,
         `SDS_FLG_ADVISORY, `SDS_ID_ECC} :
        {32'h0, ecc_count, `SDS_PCT_FULL,
         `SDS_FLG_ADVISORY, `SDS_ID_ECC};
    // bytes 362 to 397: off-line and self-test fields zero, caps, then
    // content version at 386, commit, wear threshold, global flags
    wire [287:0] tail = {7'h0, global_bbm, 7'h0, global_wl, wear_thr, commit_cnt,
                         content_ver, 128'h0, `SDS_SMART_CAPS, 48'h0};

    always @* begin
        gen_byte = 8'h00;
        off = 9'h000;
        if (idx_reg[8:0] < `SDS_ENT_SPARE) begin
            gen_byte = ver_word[{idx_reg[0], 3'b000} +: 8];
        end else if (idx_reg[8:0] < `SDS_ENT_ERASE) begin
            off = idx_reg[8:0] - `SDS_ENT_SPARE;
            gen_byte = ent_spare[{off[3:0], 3'b000} +: 8];
        end else if (idx_reg[8:0] < `SDS_ENT_ECC) begin
            off = idx_reg[8:0] - `SDS_ENT_ERASE;
            gen_byte = ent_erase[{off[3:0], 3'b000} +: 8];
        end else if (idx_reg[8:0] < `SDS_ENT_END) begin
            off = idx_reg[8:0] - `SDS_ENT_ECC;
            gen_byte = ent_ecc[{off[3:0], 3'b000} +: 8];
        end else if (idx_reg[8:0] >= `SDS_TAIL_BASE && idx_reg[8:0] < `SDS_TAIL_END) begin
            off = idx_reg[8:0] - `SDS_TAIL_BASE;
            gen_byte = tail[{off[5:0], 3'b000} +: 8];
        end else if (idx_reg[8:0] == `SDS_CHK_OFS) begin
            gen_byte = chk_reg;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        rd_next = 32'h0000_0000;
        if (!mapped) begin
            rd_next = 32'h0000_0000;
        end else if (ridx == `SDS_REG_STATUS) begin
            // byte index, done, threshold, abort, data ready, busy
            rd_next = {6'h00, idx_reg, 11'h000, done_reg, thr_reg, abort_reg,
                       (state_reg == ST_HOLD), busy};
        end else if (ridx == `SDS_REG_DATA) begin
            rd_next = (state_reg == ST_HOLD) ? {16'h0000, word_reg} : 32'h0000_0000;
        end else begin
            rd_next = regs_reg[ridx];
        end
    end

    // ----------------------------------------
    // byte-lane merge for register writes
    // ----------------------------------------
    wire [31:0] wr_merged;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign wr_merged[lane*8 +: 8] = avs_byteenable[lane] ?
                avs_writedata[lane*8 +: 8] : regs_reg[ridx][lane*8 +: 8];
        end
    endgenerate

    // ----------------------------------------
    // bus handshake and register writes
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            div_start_reg <= 1'b0;
            for (i = 0; i <= 12; i = i + 1) begin
                regs_reg[i] <= 32'h0000_0000;
            end
            regs_reg[`SDS_REG_CFG] <= `SDS_RST_CFG;
            regs_reg[`SDS_REG_LIFE] <= `SDS_RST_LIFE;
        end else begin
            div_start_reg <= 1'b0;
            if (take) begin
                avs_waitrequest <= 1'b0;
                if (avs_read) begin
                    avs_readdata <= rd_next;
                end else if (writable) begin
                    regs_reg[ridx] <= wr_merged;
                    if (ridx == `SDS_REG_SPARE_SEL) begin
                        div_start_reg <= 1'b1;
                    end
                end
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // worst values
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spare_worst_reg <= `SDS_PCT_FULL;
            erase_worst_reg <= `SDS_PCT_FULL;
        end else begin
            if (spare_val < spare_worst_reg) begin
                spare_worst_reg <= spare_val;
            end
            if (life < erase_worst_reg) begin
                erase_worst_reg <= life;
            end
        end
    end

    // ----------------------------------------
    // threshold check
    // ----------------------------------------
    wire spare_low = (spare_val < spare_thr);
    wire erase_low = (life < erase_thr);

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            thr_reg <= 1'b0;
        end else begin
            // ecc count is deliberately left out of this check
            thr_reg <= spare_low || erase_low;
        end
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            idx_reg <= 10'h000;
            sum_reg <= 8'h00;
            chk_reg <= 8'h00;
            word_reg <= 16'h0000;
            abort_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_go) begin
                        abort_reg <= 1'b0;
                        done_reg <= 1'b0;
                        idx_reg <= 10'h000;
                        sum_reg <= 8'h00;
                        chk_reg <= 8'h00;
                        if (!sig_ok) begin
                            abort_reg <= 1'b1;
                        end else if (feat == `SDS_FEAT_READ) begin
                            state_reg <= ST_WAIT;
                        end else if (feat == `SDS_FEAT_THRESH || feat == `SDS_FEAT_AUTOSAVE ||
                                     feat == `SDS_FEAT_ENABLE || feat == `SDS_FEAT_DISABLE ||
                                     feat == `SDS_FEAT_STATUS) begin
                            done_reg <= 1'b1;
                        end else begin
                            abort_reg <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    // a running percentage must settle so both passes see one value
                    if (!div_busy) begin
                        state_reg <= ST_SUM;
                    end
                end
                ST_SUM: begin
                    // first pass adds bytes 0..510 to form the checksum
                    sum_reg <= sum_reg + gen_byte;
                    idx_reg <= idx_reg + 10'h001;
                    if (idx_reg == `SDS_LAST_SUM) begin
                        chk_reg <= 8'h00 - (sum_reg + gen_byte);
                        idx_reg <= 10'h000;
                        state_reg <= ST_LO;
                    end
                end
                ST_LO: begin
                    word_reg[7:0] <= gen_byte;
                    idx_reg <= idx_reg + 10'h001;
                    state_reg <= ST_HI;
                end
                ST_HI: begin
                    word_reg[15:8] <= gen_byte;
                    idx_reg <= idx_reg + 10'h001;
                    state_reg <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (pop) begin
                        if (idx_reg == `SDS_SECTOR_END) begin
                            state_reg <= ST_IDLE;
                            done_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_LO;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sim/sds_builder_sva.sv
// assertion checker for the smart sector builder register port
`timescale 1ns/10ps
`default_nettype none
module sds_builder_sva #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // handshake steps
    // ----------------------------------------
    sequence s_taken_wr;
        avs_write && avs_waitrequest;
    endsequence
    sequence s_taken_reg_rd;
        avs_read && avs_waitrequest && avs_address[5:2] != 4'h2;
    endsequence
    sequence s_one_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_WR_ACK: assert property (s_taken_wr |=> s_one_ack)
        else $error("write not answered in one cycle");
    AST_RD_ACK: assert property (s_taken_reg_rd |=> s_one_ack)
        else $error("register read not answered in one cycle");
    AST_ACK_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
        else $error("answer without a request");
    AST_IDLE_WAIT: assert property ((!avs_read && !avs_write) [*2] |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    AST_DATA_BOUND: assert property (avs_read && avs_address[5:2] == 4'h2 |-> ##[0:600] !avs_waitrequest)
        else $error("sector word never delivered");
    AST_RDATA_HOLD: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
        else $error("read data changed outside a read answer");
    AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && avs_address[7:6] == 2'b00
        && avs_address[5:2] > 4'hc |=> !avs_waitrequest && avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RESET_WAIT: assert property ($fell(rst) |-> avs_waitrequest)
        else $error("waitrequest low at reset release");
endmodule
bind sds_builder sds_builder_sva #(.CNT_W(CNT_W)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// >>> sim/sds_host_bfm.sv
// host-side avalon-mm master model issuing smart commands
`timescale 1ns/10ps
`default_nettype none
module sds_host_bfm (
    // clock
    input wire logic ref_clk,
    // avalon-mm master
    output var logic [7:0] avs_address,
    output var logic avs_read,
    output var logic avs_write,
    output var logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // holds the request until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        integer n;
        begin
            @(posedge ref_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= ~wr;
            @(posedge ref_clk);
            for (n = 0; n < 2000 && avs_waitrequest !== 1'b0; n++) @(posedge ref_clk);
            if (avs_waitrequest !== 1'b0) sds_builder_test.hang();
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    // task file image: feature, cylinder low signature, cylinder high
    task automatic smart(input logic [7:0] feat, input logic [7:0] cyl_hi);
        wr(8'h00, {8'h00, cyl_hi, 8'h4f, feat});
    endtask
endmodule
`default_nettype wire

// >>> sim/sds_builder_test.sv
// self-checking testbench for the smart sector builder
`timescale 1ns/10ps
`default_nettype none
`include "sds_defs.vh"
module sds_builder_test;
    logic ref_clk;
    logic rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    integer n_mismatch;
    integer checks_done;
    logic [7:0] exp_b [0:511];
    logic [31:0] rv;
    // ----------------------------------------
    // clock and instances
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    sds_builder #(.CNT_W(16)) dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    sds_host_bfm host_u (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task hang;
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t wait ran out", $time);
        summarize;
    endtask
    task automatic wreg(input logic [3:0] i, input logic [31:0] d);
        host_u.wr({2'b00, i, 2'b00}, d);
    endtask
    task automatic rreg(input logic [3:0] i);
        host_u.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, rv);
    endtask
    task automatic put(input integer a, input integer n, input logic [63:0] v);
        for (int j = 0; j < n; j++) exp_b[a + j] = v[8 * j +: 8];
    endtask
    // expected sector for the values loaded by t_load
    task automatic build(input logic newl, input logic [15:0] cver, input logic wl,
        input logic bbm);
        integer s;
        logic [7:0] sum;
        begin
            s = newl ? 1 : 0;
            for (int k = 0; k < 512; k++) exp_b[k] = 8'h00;
            put(0, 2, newl ? 16'h0010 : 16'h0004);
            put(2, 1, 8'hc4);
            put(3, 2, 16'h0003);
            put(5, 1, 8'h4b);
            if (newl) put(6, 1, 8'h4b);
            put(6 + s, 2, 16'd40);
            put(8 + s, 2, 16'd30);
            if (!newl) put(10, 2, 16'h0123);
            put(newl ? 11 : 12, 2, 16'h0456);
            put(14, 1, 8'he5);
            put(15, 2, 16'h0002);
            put(17, 1, 8'h50);
            if (newl) put(18, 1, 8'h50);
            put(18 + s, newl ? 6 : 8, 64'h5566_7788_1122_3344);
            put(26, 1, 8'hcb);
            put(27, 2, 16'h0002);
            put(29, 1, 8'h64);
            if (newl) put(30, 1, 8'h64);
            put(30 + s, 4, 32'h0a0b_0c0d);
            put(368, 2, 16'h0003);
            put(386, 2, cver);
            put(388, 4, 32'h0102_0304);
            put(392, 4, 32'h0000_0500);
            put(396, 1, wl);
            put(397, 1, bbm);
            sum = 8'h00;
            for (int k = 0; k < 511; k++) sum = sum + exp_b[k];
            exp_b[511] = 8'h00 - sum;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rreg(`SDS_REG_CFG);
        chk(rv, `SDS_RST_CFG, "cfg reset");
        rreg(`SDS_REG_LIFE);
        chk(rv, `SDS_RST_LIFE, "life reset");
        wreg(4'hd, 32'hffff_ffff);
        rreg(4'hd);
        chk(rv, 32'h0, "unmapped read");
        $display("test registers done");
    endtask
    task automatic t_load;
        wreg(`SDS_REG_SPARE_SEL, 32'h001e_0028);
        wreg(`SDS_REG_SPARE_SUM, 32'h0456_0123);
        wreg(`SDS_REG_LIFE, 32'h0000_0050);
        wreg(`SDS_REG_ERASE_LO, 32'h1122_3344);
        wreg(`SDS_REG_ERASE_HI, 32'h5566_7788);
        wreg(`SDS_REG_ECC, 32'h0a0b_0c0d);
        wreg(`SDS_REG_COMMIT, 32'h0102_0304);
        wreg(`SDS_REG_WEAR_THR, 32'h0000_0500);
        $display("test load done");
    endtask
    task automatic t_sector(input logic [31:0] cfg);
        integer n;
        begin
            wreg(`SDS_REG_CFG, cfg);
            build(cfg[0], cfg[31:16], cfg[1], cfg[2]);
            host_u.smart(`SDS_FEAT_READ, `SDS_SIG_CYL_HI);
            rv = 32'h0;
            for (n = 0; n < 1000 && rv[1] !== 1'b1; n++) rreg(`SDS_REG_STATUS);
            if (rv[1] !== 1'b1) hang();
            for (int k = 0; k < 256; k++) begin
                rreg(`SDS_REG_DATA);
                chk(rv[7:0], exp_b[2 * k], "sector even byte");
                chk(rv[15:8], exp_b[2 * k + 1], "sector odd byte");
            end
            rreg(`SDS_REG_STATUS);
            chk({rv[4], rv[0]}, 2'b10, "one sector only");
            rreg(`SDS_REG_DATA);
            chk(rv, 32'h0, "no data past one sector");
            $display("test sector cfg %h done", cfg);
        end
    endtask
    task automatic t_status;
        logic [15:0] thr [0:3];
        begin
            thr = '{16'h004c, 16'h004b, 16'h5100, 16'h5000};
            for (int k = 0; k < 4; k++) begin
                wreg(`SDS_REG_THRESH, {16'h0000, thr[k]});
                host_u.smart(`SDS_FEAT_STATUS, `SDS_SIG_CYL_HI);
                rreg(`SDS_REG_STATUS);
                chk(rv[4], 1'b1, "status done");
                chk(rv[3], k % 2 == 0, "threshold");
            end
            $display("test return status done");
        end
    endtask
    task automatic t_cmds;
        logic [7:0] f [0:6];
        begin
            f = '{`SDS_FEAT_THRESH, `SDS_FEAT_AUTOSAVE, `SDS_FEAT_ENABLE, `SDS_FEAT_DISABLE,
                `SDS_FEAT_STATUS, 8'hd3, `SDS_FEAT_READ};
            for (int k = 0; k < 7; k++) begin
                host_u.smart(f[k], k == 6 ? 8'hc3 : `SDS_SIG_CYL_HI);
                rreg(`SDS_REG_STATUS);
                chk(rv[2], k > 4, "abort");
                if (k < 5) chk({rv[4], rv[1]}, 2'b10, "done without data");
            end
            $display("test commands done");
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        n_mismatch = 0;
        checks_done = 0;
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_load;
        t_sector(32'h0002_0002);
        t_status;
        t_cmds;
        t_sector(32'h0000_0005);
        summarize;
    end
endmodule
`default_nettype wire
